// ---- pkg/dcq_pkg.sv ----
// Shared constants and types for the data request qualifier link
package dcq_pkg;
  localparam int LANES = 8;
  localparam int PRIO_W = 2;
  localparam int ADDR_W = 32;
  localparam int ADDR_LANE_SEL_BIT = 2;
  localparam logic [7:0] LANES_IDLE = 8'h00;
  localparam logic [1:0] PRIO_IDLE = 2'h0;
  localparam logic [1:0] PRIO_LOWEST = 2'h0;
  localparam logic [1:0] PRIO_NEXT_LOWEST = 2'h1;
  localparam logic [1:0] PRIO_NEXT_HIGHEST = 2'h2;
  localparam logic [1:0] PRIO_HIGHEST = 2'h3;
  localparam int PRIO_HW_BIT = 0;
  localparam int PRIO_SW_BIT = 1;
  localparam int REQ_GAP_CYCLES = 1;
  localparam logic SLAVE_WIDTH_32 = 1'b0;
  localparam logic SLAVE_WIDTH_64 = 1'b1;
  typedef logic [7:0] dcq_lanes_t;
  typedef logic [1:0] dcq_prio_t;

  // Contiguous run of 1..4 bytes inside one 4-byte half
  function automatic logic dcq_lanes_legal(input logic [3:0] half);
    logic ok;
    ok = 1'b0;
    unique case (half)
      4'h8, 4'hC, 4'hE, 4'hF, 4'h4, 4'h6, 4'h7, 4'h2, 4'h3, 4'h1: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction
endpackage

// ---- pkg/dcq_link_if.sv ----
// Interface joining the data request master and its bus slave
interface dcq_link_if;
  import dcq_pkg::*;
  logic data_req_valid;
  logic data_req_abort;
  logic data_req_read;
  logic data_req_line;
  logic [ADDR_W-1:0] data_req_addr;
  dcq_lanes_t data_req_lane_enables;
  dcq_prio_t data_req_priority;
  logic data_req_addr_ack;
  logic slave_width_indicator;
  modport master (
    output data_req_valid, data_req_abort, data_req_read, data_req_line,
    output data_req_addr, data_req_lane_enables, data_req_priority,
    input data_req_addr_ack, slave_width_indicator
  );
  modport slave (
    input data_req_valid, data_req_abort, data_req_read, data_req_line,
    input data_req_addr, data_req_lane_enables, data_req_priority,
    output data_req_addr_ack, slave_width_indicator
  );
endinterface

// ---- hdl/dcq_master.sv ----
// Data cache request qualifier master: lanes, priority and abort
import dcq_pkg::*;
// How it works
// - Lanes mark valid bytes on word transfers
// - Lanes held stable until after acknowledge
// - Narrow slave picks lane half by address
// - Narrow slave writes from upper data half
// - Narrow read data feeds both halves
// - Only contiguous one-to-four byte patterns driven
// - Lower lanes map per slave width
// - Two-bit priority, 11 highest
// - Priority held until after acknowledge, except that a stall can raise the low bit
// - Low priority bit on reads or stall
// - High priority bit from configuration bit
// - Arbiter favours data side on ties
// - Slave ignores abort without request
// - Request drops after abort, low at least two cycles
// - Aborted acknowledged read gets no data
// - Aborted write changes no memory
// - Abort only on processor reset
// - Core-only reset: finish old, drop new; here core_reset_in aborts a request still waiting for acknowledge
// - Address acknowledge lasts one cycle
// - Slave reports width during acknowledge
// - No request until processor reset completes
module dcq_master (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Core side
  input wire logic core_reset_in,
  input wire logic cfg_data_priority_high_bit_in,
  input wire logic stall_in,
  input wire logic issue_in,
  input wire logic issue_read_in,
  input wire logic issue_line_in,
  input wire logic [dcq_pkg::ADDR_W-1:0] issue_addr_in,
  input wire logic [dcq_pkg::LANES-1:0] issue_lanes_in,
  output logic issue_ready_out,
  output logic issue_done_out,
  output logic issue_aborted_out,
  output logic last_slave_wide_out,
  // Bus link
  dcq_link_if.master link
);
  import dcq_pkg::*;

  // HALT parks the master while the core is in reset
  typedef enum {ST_IDLE, ST_REQ, ST_GAP, ST_HALT} dcq_state_t;

  dcq_state_t state_reg, state_next;
  // Qualifier registers; all but abort and the priority low bit hold while a request is up
  logic valid_reg, valid_next;
  logic abort_reg, abort_next;
  logic read_reg, read_next;
  logic line_reg, line_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  dcq_lanes_t lanes_reg, lanes_next;
  dcq_prio_t prio_reg, prio_next;
  // Status back to the core: done and aborted strobes, ready and last slave width levels
  logic done_reg, done_next;
  logic aborted_reg, aborted_next;
  logic wide_reg, wide_next;
  logic ready_reg, ready_next;
  logic upper_ok, lower_ok;
  logic lanes_ok;

  // Reject any pattern that is not one contiguous run in one half
  // Line transfers bypass this check, their lanes are forced idle
  always_comb begin
    upper_ok = dcq_lanes_legal(issue_lanes_in[7:4]) && (issue_lanes_in[3:0] == 4'h0);
    lower_ok = dcq_lanes_legal(issue_lanes_in[3:0]) && (issue_lanes_in[7:4] == 4'h0);
    // Spanning both halves would cross a word, never legal
    lanes_ok = upper_ok || lower_ok;
  end

  // Next-state logic for the request, its qualifiers and the core handshake
  // Abort and done are one-cycle strobes, so they default low every cycle
  always_comb begin
    state_next = state_reg;
    valid_next = valid_reg;
    abort_next = 1'b0;
    read_next = read_reg;
    line_next = line_reg;
    addr_next = addr_reg;
    lanes_next = lanes_reg;
    prio_next = prio_reg;
    done_next = 1'b0;
    aborted_next = 1'b0;
    wide_next = wide_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // A core reset seen while idle parks without ever raising a request
        if (core_reset_in) begin
          state_next = ST_HALT;
        end else if (issue_in && (issue_line_in || lanes_ok)) begin
          state_next = ST_REQ;
          valid_next = 1'b1;
          read_next = issue_read_in;
          line_next = issue_line_in;
          addr_next = issue_addr_in;
          // Lanes meaningless on line transfers, drive them idle
          lanes_next = issue_line_in ? LANES_IDLE : issue_lanes_in;
          prio_next[PRIO_SW_BIT] = cfg_data_priority_high_bit_in;
          prio_next[PRIO_HW_BIT] = issue_read_in || stall_in;
        end
      end
      ST_REQ: begin
        // Stall may raise urgency while waiting, without moving other qualifiers
        if (stall_in) begin
          prio_next[PRIO_HW_BIT] = 1'b1;
        end
        // Abort outranks a same-cycle acknowledge: the slave drops that one
        if (abort_reg) begin
          // Abort shown this cycle: request drops next cycle and stays down
          state_next = ST_HALT;
          valid_next = 1'b0;
          aborted_next = 1'b1;
        end else if (core_reset_in) begin
          abort_next = 1'b1;
        end else if (link.data_req_addr_ack) begin
          // Qualifiers held into the cycle after acknowledge
          state_next = ST_GAP;
          valid_next = 1'b0;
          done_next = 1'b1;
          wide_next = link.slave_width_indicator;
        end
      end
      ST_GAP: begin
        // One GAP cycle plus IDLE keeps the request low at least two cycles, then clear lanes and priority
        state_next = core_reset_in ? ST_HALT : ST_IDLE;
        lanes_next = LANES_IDLE;
        prio_next = PRIO_IDLE;
      end
      ST_HALT: begin
        // Bus is not reset with the core, so nothing else to clean up
        valid_next = 1'b0;
        lanes_next = LANES_IDLE;
        prio_next = PRIO_IDLE;
        if (!core_reset_in) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    // Registered so the core sees ready straight from a flop
    ready_next = (state_next == ST_IDLE);
  end

  // Plain register stage; reset drives an idle master onto the bus
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      valid_reg <= 1'b0;
      abort_reg <= 1'b0;
      read_reg <= 1'b0;
      line_reg <= 1'b0;
      addr_reg <= '0;
      lanes_reg <= LANES_IDLE;
      prio_reg <= PRIO_IDLE;
      done_reg <= 1'b0;
      aborted_reg <= 1'b0;
      wide_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      valid_reg <= valid_next;
      abort_reg <= abort_next;
      read_reg <= read_next;
      line_reg <= line_next;
      addr_reg <= addr_next;
      lanes_reg <= lanes_next;
      prio_reg <= prio_next;
      done_reg <= done_next;
      aborted_reg <= aborted_next;
      wide_reg <= wide_next;
      ready_reg <= ready_next;
    end
  end

  // Link and core outputs come straight from the registers above
  assign link.data_req_valid = valid_reg;
  assign link.data_req_abort = abort_reg;
  assign link.data_req_read = read_reg;
  assign link.data_req_line = line_reg;
  assign link.data_req_addr = addr_reg;
  assign link.data_req_lane_enables = lanes_reg;
  assign link.data_req_priority = prio_reg;
  assign issue_ready_out = ready_reg;
  assign issue_done_out = done_reg;
  assign issue_aborted_out = aborted_reg;
  assign last_slave_wide_out = wide_reg;
endmodule // dcq_master

// ---- hdl/dcq_slave.sv ----
// Bus slave end: acknowledge, width report, lane steering and abort handling
import dcq_pkg::*;
module dcq_slave (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Slave configuration
  input wire logic wide_slave_in,
  input wire logic ack_enable_in,
  // Bus link
  dcq_link_if.slave link,
  // Accepted request toward the memory side
  output logic acc_valid_out,
  output logic acc_read_out,
  output logic acc_line_out,
  output logic [dcq_pkg::ADDR_W-1:0] acc_addr_out,
  output logic [3:0] acc_lanes_out,
  output logic acc_upper_out,
  output logic acc_dropped_out
);
  import dcq_pkg::*;

  logic ack_reg, ack_next;
  logic acc_valid_reg, acc_valid_next;
  logic acc_read_reg, acc_read_next;
  logic acc_line_reg, acc_line_next;
  logic [ADDR_W-1:0] acc_addr_reg, acc_addr_next;
  logic [3:0] acc_lanes_reg, acc_lanes_next;
  logic acc_upper_reg, acc_upper_next;
  logic dropped_reg, dropped_next;
  logic sel_lower;

  always_comb begin
    // Address bit 29 in big-endian order is bit 2 here
    sel_lower = link.data_req_addr[ADDR_LANE_SEL_BIT];
    // One-cycle acknowledge, never back to back on the same request
    ack_next = link.data_req_valid && ack_enable_in && !ack_reg;
    acc_valid_next = 1'b0;
    dropped_next = 1'b0;
    acc_read_next = acc_read_reg;
    acc_line_next = acc_line_reg;
    acc_addr_next = acc_addr_reg;
    acc_lanes_next = acc_lanes_reg;
    acc_upper_next = acc_upper_reg;
    if (ack_reg && link.data_req_valid) begin
      // Abort only counts alongside a live request
      if (link.data_req_abort) begin
        dropped_next = 1'b1;
      end else begin
        acc_valid_next = 1'b1;
        acc_read_next = link.data_req_read;
        acc_line_next = link.data_req_line;
        acc_addr_next = link.data_req_addr;
        // Narrow slave: both halves land on bytes 0..3; wide keeps the half
        acc_lanes_next = !sel_lower ?
                         link.data_req_lane_enables[7:4] :
                         link.data_req_lane_enables[3:0];
        acc_upper_next = wide_slave_in ? !sel_lower : 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_reg <= 1'b0;
      acc_valid_reg <= 1'b0;
      acc_read_reg <= 1'b0;
      acc_line_reg <= 1'b0;
      acc_addr_reg <= '0;
      acc_lanes_reg <= 4'h0;
      acc_upper_reg <= 1'b0;
      dropped_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      acc_valid_reg <= acc_valid_next;
      acc_read_reg <= acc_read_next;
      acc_line_reg <= acc_line_next;
      acc_addr_reg <= acc_addr_next;
      acc_lanes_reg <= acc_lanes_next;
      acc_upper_reg <= acc_upper_next;
      dropped_reg <= dropped_next;
    end
  end

  assign link.data_req_addr_ack = ack_reg;
  assign link.slave_width_indicator = wide_slave_in ? SLAVE_WIDTH_64 : SLAVE_WIDTH_32;
  assign acc_valid_out = acc_valid_reg;
  assign acc_read_out = acc_read_reg;
  assign acc_line_out = acc_line_reg;
  assign acc_addr_out = acc_addr_reg;
  assign acc_lanes_out = acc_lanes_reg;
  assign acc_upper_out = acc_upper_reg;
  assign acc_dropped_out = dropped_reg;
endmodule // dcq_slave

// ---- verification/dcq_link_asserts.sv ----
// Protocol checks on the data request link between master and slave
module dcq_link_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Link signals
  input wire logic data_req_valid,
  input wire logic data_req_abort,
  input wire logic data_req_read,
  input wire logic data_req_line,
  input wire dcq_pkg::dcq_lanes_t data_req_lane_enables,
  input wire dcq_pkg::dcq_prio_t data_req_priority,
  input wire logic data_req_addr_ack
);
  import dcq_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence req_held; data_req_valid && !data_req_abort; endsequence
  sequence req_acked; data_req_valid && data_req_addr_ack; endsequence
  sequence req_aborted; data_req_valid && data_req_abort; endsequence
  function automatic logic run_ok(input logic [3:0] h);
    return h inside {4'h8, 4'hC, 4'hE, 4'hF, 4'h4, 4'h6, 4'h7, 4'h2, 4'h3, 4'h1};
  endfunction
  chk_lanes_held: assert property (req_held |=> $stable(data_req_lane_enables))
    else $error("lane enables moved during a request");
  chk_prio_held: assert property (req_held |=> $stable(data_req_priority[1])
    && !$fell(data_req_priority[0])) else $error("priority moved during a request");
  chk_lanes_legal: assert property (data_req_valid && !data_req_line |->
    (run_ok(data_req_lane_enables[7:4]) && data_req_lane_enables[3:0] == 4'h0) ||
    (run_ok(data_req_lane_enables[3:0]) && data_req_lane_enables[7:4] == 4'h0))
    else $error("illegal lane pattern");
  chk_read_prio: assert property (data_req_valid && data_req_read |-> data_req_priority[0])
    else $error("read without low priority bit");
  chk_abort_drop: assert property (req_aborted |=> !data_req_valid [*2])
    else $error("request not dropped after abort");
  chk_abort_in_req: assert property (data_req_abort |-> data_req_valid)
    else $error("abort outside a request");
  chk_ack_single: assert property (req_acked |=> !data_req_addr_ack && !data_req_valid)
    else $error("acknowledge or request held too long");
  chk_ack_cause: assert property (data_req_addr_ack |-> $past(data_req_valid))
    else $error("acknowledge without request");
  // Own disable so the reset cycles themselves are watched
  chk_reset_idle: assert property (@(posedge clk_in) disable iff (1'b0) rst_in |=>
    !data_req_valid && !data_req_abort && data_req_lane_enables == LANES_IDLE &&
    data_req_priority == PRIO_IDLE) else $error("master not idle in reset");
endmodule // dcq_link_asserts

// ---- verification/dcq_tb.sv ----
// Self-checking bench for the master and slave pair on one link
module dcq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dcq_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic core_reset_in = 1'b0;
  logic cfg_hi = 1'b0, stall = 1'b0, issue = 1'b0, rd = 1'b0, ln = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [7:0] lanes = 8'h00;
  logic wide = 1'b1, ack_en = 1'b1;
  logic done, abrt, wide_last, accv, accu, drop;
  logic [3:0] accl, al;
  logic au;
  dcq_lanes_t lv;
  dcq_prio_t pv;
  int err_count = 0, n_compared = 0;
  int cv, ca, cd, cdn, cab;
  dcq_link_if link_i ();
  dcq_master dcq_master_i (.clk_in(clk_in), .rst_in(rst_in), .core_reset_in(core_reset_in),
    .cfg_data_priority_high_bit_in(cfg_hi), .stall_in(stall), .issue_in(issue),
    .issue_read_in(rd), .issue_line_in(ln), .issue_addr_in(addr), .issue_lanes_in(lanes),
    .issue_ready_out(), .issue_done_out(done), .issue_aborted_out(abrt),
    .last_slave_wide_out(wide_last), .link(link_i.master));
  dcq_slave dcq_slave_i (.clk_in(clk_in), .rst_in(rst_in), .wide_slave_in(wide),
    .ack_enable_in(ack_en), .link(link_i.slave), .acc_valid_out(accv), .acc_read_out(),
    .acc_line_out(), .acc_addr_out(), .acc_lanes_out(accl), .acc_upper_out(accu),
    .acc_dropped_out(drop));
  dcq_link_asserts dcq_link_asserts_i (.clk_in(clk_in), .rst_in(rst_in),
    .data_req_valid(link_i.data_req_valid), .data_req_abort(link_i.data_req_abort),
    .data_req_read(link_i.data_req_read), .data_req_line(link_i.data_req_line),
    .data_req_lane_enables(link_i.data_req_lane_enables),
    .data_req_priority(link_i.data_req_priority), .data_req_addr_ack(link_i.data_req_addr_ack));
  always #12.5 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Counts link events over n edges; ends on a falling edge for the next drive
  task automatic watch(input int n);
    {cv, ca, cd, cdn, cab} = '0;
    repeat (n) begin
      @(posedge clk_in);
      if (link_i.data_req_valid === 1'b1) begin
        cv++;
        lv = link_i.data_req_lane_enables;
        pv = link_i.data_req_priority;
      end
      if (accv === 1'b1) begin
        ca++;
        al = accl;
        au = accu;
      end
      cd += int'(drop === 1'b1);
      cdn += int'(done === 1'b1);
      cab += int'(abrt === 1'b1);
    end
    @(negedge clk_in);
  endtask
  task automatic op(input logic r, input logic l, input logic [31:0] a, input logic [7:0] e,
      input logic cr, input int n);
    rd = r;
    ln = l;
    addr = a;
    lanes = e;
    issue = 1'b1;
    @(negedge clk_in);
    issue = 1'b0;
    core_reset_in = cr;
    watch(n);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    logic [3:0] h [10] = '{4'h8, 4'hC, 4'hE, 4'hF, 4'h4, 4'h6, 4'h7, 4'h2, 4'h3, 4'h1};
    logic [7:0] e;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 20; i++) begin
      cfg_hi = i[0];
      wide = i[1];
      e = (i < 10) ? {h[i], 4'h0} : {4'h0, h[i - 10]};
      op(i[2], 1'b0, {29'h0, i >= 10, 2'h0}, e, 1'b0, 6);
      chk(cv, 2);
      chk(pv, {i[0], i[2]});
      chk(lv, e);
      chk(al, (i >= 10) ? e[3:0] : e[7:4]);
      chk(au, wide ? i < 10 : 1'b1);
      chk(wide_last, wide);
      chk(ca, 1);
    end
    $display("test lanes done");
    op(1'b0, 1'b0, 32'h0, 8'h81, 1'b0, 6);
    chk(cv, 0);
    op(1'b1, 1'b1, 32'h20, 8'h00, 1'b0, 6);
    chk(ca, 1);
    ack_en = 1'b0;
    stall = 1'b1;
    op(1'b0, 1'b0, 32'h4, 8'h0F, 1'b0, 4);
    chk(cv, 4);
    chk(pv[0], 1'b1);
    ack_en = 1'b1;
    stall = 1'b0;
    watch(4);
    chk(cdn, 1);
    $display("test stall done");
    // Pending abort first, then abort landing on the acknowledge
    for (int k = 0; k < 2; k++) begin
      ack_en = k[0];
      op(1'b1, 1'b0, 32'h8, 8'hF0, 1'b1, 6);
      chk(cab, 1);
      chk(cd, k);
      chk(ca, 0);
      op(1'b1, 1'b0, 32'h8, 8'hF0, 1'b1, 6);
      chk(cv, 0);
      core_reset_in = 1'b0;
      watch(3);
    end
    op(1'b0, 1'b0, 32'h0, 8'h10, 1'b0, 6);
    chk(cdn, 1);
    $display("test abort done");
    test_done();
  end
  initial begin
    #(25 * 1000);
    err_count++;
    test_done();
  end
endmodule // dcq_tb
